// file: hdl/lrp_defines.vh
// constants for the low-power dram refresh and power-state block
`ifndef LRP_DEFINES_VH
`define LRP_DEFINES_VH

// command encoding {cs_n, ras_n, cas_n, we_n}
`define LRP_CMD_REFRESH     4'h1
`define LRP_CMD_NOP         4'h7
`define LRP_CMD_ACTIVE      4'h3
`define LRP_CMD_PRECHARGE   4'h2
`define LRP_CMD_DEEP        4'h6
`define LRP_CMD_READ        4'h5
`define LRP_CMD_WRITE       4'h4
`define LRP_CMD_MRS         4'h0
`define LRP_CS_BIT          3

// device geometry
`define LRP_ROW_W           14
`define LRP_BANK_W          2
`define LRP_NBANK           4
`define LRP_ALLB_BIT        10
`define LRP_ROW_ONE         14'h0001
`define LRP_ROW_ZERO        14'h0000

// timing in ns and clock period in ns
`define LRP_CLK_NS          25
`define LRP_TRFC_NS         110
`define LRP_TXSR_NS         120
`define LRP_TXP_NS          25
`define LRP_TXSR_MIN_CYC    2
`define LRP_CNT_W           8
`define LRP_CNT_ONE         8'h01
`define LRP_CNT_ZERO        8'h00

// self refresh internal interval in cycles, slowed when cool
`define LRP_SREF_HOT_CYC    8'h40
`define LRP_SREF_COOL_CYC   8'hc0

// partial array field: 0 full, 1 half, 2 quarter
`define LRP_PAR_W           2
`define LRP_PAR_FULL        2'h0
`define LRP_PAR_HALF        2'h1
`define LRP_ROW_HALF_MASK   14'h1fff
`define LRP_ROW_QTR_MASK    14'h0fff

`endif

// file: hdl/lrp_power_states.v
// refresh and power-state controller of a low-power ddr dram
// Contract
// [R1] each refresh needs its own command
// [R2] refresh row from internal counter
// [R3] refresh busy for trfc, nop only
// [R4] clock enable high during refresh
// [R5] banks precharged before refresh
// [R6] self refresh: refresh with cke low
// [R7] banks idle before self refresh
// [R8] self refresh ignores all but cke
// [R9] self refresh partial, temperature paced
// [R10] self refresh exit needs nop txsr
// [R11] self refresh not an auto refresh
// [R12] cke low enters precharge/active power-down
// [R13] power-down disables buffers except cke
// [R14] power-down exit with nop, txp
// [R15] no column access at power-down
// [R16] leave power-down in time for refresh
// [R17] deep sleep needs idle banks
// [R18] deep sleep command with cke low
// [R19] deep sleep exit needs reinitialisation
// [R20] frequency change keeps timings
// [R21] clock stop after operations finish
// [R22] clock stop cke high, nop after
`include "lrp_defines.vh"
`default_nettype none
module lrp_power_states (
  input  wire                    i_clock,
  input  wire                    i_srst,
  input  wire                    i_cke,
  input  wire                    i_cs_n,
  input  wire                    i_ras_n,
  input  wire                    i_cas_n,
  input  wire                    i_we_n,
  input  wire [`LRP_ROW_W-1:0]   i_addr,
  input  wire [`LRP_BANK_W-1:0]  i_bank,
  input  wire [`LRP_PAR_W-1:0]   i_partial_array_retention,
  input  wire                    i_temp_hot,
  input  wire                    i_init_done,
  output reg  [`LRP_ROW_W-1:0]   o_refresh_row,
  output reg                     o_refresh_pulse,
  output reg                     o_buffers_on,
  output reg  [5:0]              o_state,
  output reg  [`LRP_NBANK-1:0]   o_bank_open,
  output reg                     o_data_lost,
  output reg                     o_cmd_error
);
  localparam [`LRP_CNT_W-1:0] TRFC_CYC =
    (`LRP_TRFC_NS + `LRP_CLK_NS - 1) / `LRP_CLK_NS;
  localparam [`LRP_CNT_W-1:0] TXSR_RAW =
    (`LRP_TXSR_NS + `LRP_CLK_NS - 1) / `LRP_CLK_NS;
  localparam [`LRP_CNT_W-1:0] TXSR_CYC =
    (TXSR_RAW < `LRP_TXSR_MIN_CYC) ? `LRP_TXSR_MIN_CYC : TXSR_RAW;
  localparam [`LRP_CNT_W-1:0] TXP_RAW =
    (`LRP_TXP_NS + `LRP_CLK_NS - 1) / `LRP_CLK_NS;
  localparam [`LRP_CNT_W-1:0] TXP_CYC = (TXP_RAW == 0) ? `LRP_CNT_ONE : TXP_RAW;

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_REF   = 6'h02;
  localparam [5:0] ST_SREF  = 6'h04;
  localparam [5:0] ST_PDN   = 6'h08;
  localparam [5:0] ST_DEEP  = 6'h10;
  localparam [5:0] ST_EXIT  = 6'h20;

  // pins come from the controller's domain: two flops each
  reg  [`LRP_ROW_W+`LRP_BANK_W+4:0] pin_s1_ff;
  reg  [`LRP_ROW_W+`LRP_BANK_W+4:0] pin_s2_ff;
  always @(posedge i_clock) begin
    pin_s1_ff <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank, i_addr};
    pin_s2_ff <= pin_s1_ff;
  end

  wire                   cke  = pin_s2_ff[`LRP_ROW_W+`LRP_BANK_W+4];
  wire [3:0]             cmd  = pin_s2_ff[`LRP_ROW_W+`LRP_BANK_W+3:`LRP_ROW_W+`LRP_BANK_W];
  wire [`LRP_BANK_W-1:0] bank = pin_s2_ff[`LRP_ROW_W+`LRP_BANK_W-1:`LRP_ROW_W];
  wire                   allb = pin_s2_ff[`LRP_ALLB_BIT];
  wire                   is_nop = cmd[`LRP_CS_BIT] || (cmd == `LRP_CMD_NOP);

  reg                    cke_prev_ff;
  reg  [5:0]             state_ff;
  reg  [5:0]             nxt_state;
  reg  [`LRP_CNT_W-1:0]  cnt_ff;
  reg  [`LRP_CNT_W-1:0]  nxt_cnt;
  reg  [`LRP_CNT_W-1:0]  sref_tmr_ff;
  reg  [`LRP_CNT_W-1:0]  nxt_sref_tmr;
  reg  [`LRP_NBANK-1:0]  open_ff;
  reg  [`LRP_NBANK-1:0]  nxt_open;
  reg                    lost_ff;
  reg                    nxt_lost;
  reg                    err_ff;
  reg                    nxt_err;
  reg                    step;
  wire [`LRP_ROW_W-1:0]  ctr_row;

  lrp_row_counter u_rows (
    .i_clock   (i_clock),
    .i_srst    (i_srst),
    .i_step    (step),
    .i_partial (i_partial_array_retention),
    .o_row     (ctr_row)
  );

  always @* begin
    nxt_state    = state_ff;
    nxt_cnt      = (cnt_ff != `LRP_CNT_ZERO) ? cnt_ff - `LRP_CNT_ONE : `LRP_CNT_ZERO;
    nxt_sref_tmr = sref_tmr_ff;
    nxt_open     = open_ff;
    nxt_lost     = lost_ff && !i_init_done; // see [R19]
    nxt_err      = 1'b0;
    step         = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (!cke && cke_prev_ff) begin
          if (!cmd[`LRP_CS_BIT] && cmd == `LRP_CMD_REFRESH) begin
            nxt_err      = (open_ff != {`LRP_NBANK{1'b0}}); // see [R7]
            nxt_sref_tmr = `LRP_CNT_ONE;
            nxt_state    = ST_SREF; // see [R6]
          end else if (!cmd[`LRP_CS_BIT] && cmd == `LRP_CMD_DEEP) begin
            nxt_err   = (open_ff != {`LRP_NBANK{1'b0}}); // see [R17]
            nxt_open  = {`LRP_NBANK{1'b0}};
            nxt_lost  = 1'b1; // see [R18]
            nxt_state = ST_DEEP;
          end else begin
            // precharge or active power-down follows from open_ff
            nxt_err   = !is_nop && (cmd == `LRP_CMD_READ || cmd == `LRP_CMD_WRITE); // see [R15]
            nxt_state = ST_PDN; // see [R12]
          end
        end else if (cke && !cmd[`LRP_CS_BIT]) begin
          case (cmd)
            `LRP_CMD_REFRESH: begin
              nxt_err   = (open_ff != {`LRP_NBANK{1'b0}}); // see [R5]
              step      = 1'b1; // see [R2]
              nxt_cnt   = TRFC_CYC;
              nxt_state = ST_REF; // see [R3]
            end
            `LRP_CMD_ACTIVE: begin
              nxt_open[bank] = 1'b1;
            end
            `LRP_CMD_PRECHARGE: begin
              if (allb) begin
                nxt_open = {`LRP_NBANK{1'b0}}; // see [R5]
              end else begin
                nxt_open[bank] = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_REF: begin
        // only nop with cke high is legal until trfc ends
        nxt_err = !is_nop || !cke; // see [R3] see [R4]
        if (cnt_ff == `LRP_CNT_ONE) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SREF: begin
        // internal pacing, slower when cool; address and commands ignored
        if (sref_tmr_ff == `LRP_CNT_ONE) begin
          step         = 1'b1; // see [R9]
          nxt_sref_tmr = i_temp_hot ? `LRP_SREF_HOT_CYC : `LRP_SREF_COOL_CYC;
        end else begin
          nxt_sref_tmr = sref_tmr_ff - `LRP_CNT_ONE;
        end
        if (cke) begin
          nxt_cnt   = TXSR_CYC; // see [R10]
          nxt_state = ST_EXIT;
        end // see [R8]
      end
      ST_PDN: begin
        if (cke) begin
          nxt_err   = !is_nop; // see [R14]
          nxt_cnt   = TXP_CYC;
          nxt_state = ST_EXIT;
        end
      end
      ST_DEEP: begin
        if (cke) begin
          nxt_err   = !is_nop; // see [R19]
          nxt_cnt   = TXP_CYC;
          nxt_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        nxt_err = !is_nop; // see [R10] see [R14]
        if (cnt_ff == `LRP_CNT_ONE) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= `LRP_CNT_ZERO;
      sref_tmr_ff <= `LRP_CNT_ZERO;
      open_ff     <= {`LRP_NBANK{1'b0}};
      lost_ff     <= 1'b1;
      err_ff      <= 1'b0;
      cke_prev_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sref_tmr_ff <= nxt_sref_tmr;
      open_ff     <= nxt_open;
      lost_ff     <= nxt_lost;
      err_ff      <= nxt_err;
      cke_prev_ff <= cke;
    end
  end

  // outputs registered; row is the counter value, never the address pins
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_refresh_row   <= `LRP_ROW_ZERO;
      o_refresh_pulse <= 1'b0;
      o_buffers_on    <= 1'b1;
      o_state         <= ST_IDLE;
      o_bank_open     <= {`LRP_NBANK{1'b0}};
      o_data_lost     <= 1'b1;
      o_cmd_error     <= 1'b0;
    end else begin
      o_refresh_row   <= ctr_row; // see [R2]
      o_refresh_pulse <= step;
      // buffers off in every low-power state; aligned with o_state so both agree
      o_buffers_on    <= (state_ff == ST_IDLE) || (state_ff == ST_REF) ||
                         (state_ff == ST_EXIT); // see [R13]
      o_state         <= state_ff;
      o_bank_open     <= open_ff;
      o_data_lost     <= lost_ff;
      o_cmd_error     <= err_ff;
    end
  end
endmodule
`default_nettype wire

// file: hdl/lrp_row_counter.v
// internal refresh row counter with partial-array wrap
`include "lrp_defines.vh"
`default_nettype none
module lrp_row_counter (
  input  wire                    i_clock,
  input  wire                    i_srst,
  input  wire                    i_step,
  input  wire [`LRP_PAR_W-1:0]   i_partial,
  output wire [`LRP_ROW_W-1:0]   o_row
);
  reg  [`LRP_ROW_W-1:0] row_ff;
  reg  [`LRP_ROW_W-1:0] nxt_row;
  reg  [`LRP_ROW_W-1:0] mask;

  always @* begin
    case (i_partial)
      `LRP_PAR_FULL: mask = {`LRP_ROW_W{1'b1}};
      `LRP_PAR_HALF: mask = `LRP_ROW_HALF_MASK;
      default:       mask = `LRP_ROW_QTR_MASK;
    endcase
    // wrap inside the retained portion only
    nxt_row = i_step ? ((row_ff + `LRP_ROW_ONE) & mask) : (row_ff & mask);
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      row_ff <= `LRP_ROW_ZERO;
    end else begin
      row_ff <= nxt_row;
    end
  end

  assign o_row = row_ff;
endmodule
`default_nettype wire

// file: tb/lrp_host_model.sv
// host controller model driving clock enable, command and address pins
`default_nettype none
module lrp_host_model (
  input  wire logic        i_clock,
  input  wire logic [3:0]  i_cmd,
  input  wire logic        i_cke,
  input  wire logic [13:0] i_addr,
  output var  logic        o_cke,
  output var  logic [3:0]  o_pins,
  output var  logic [13:0] o_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {o_cke, o_pins, o_addr} = {1'b1, 4'h7, 14'h0000};
  // pins launched on an edge and held a whole cycle, so the device never sees a race
  always @(posedge i_clock) begin
    o_pins <= i_cmd;
    o_cke  <= i_cke;
    o_addr <= i_addr;
  end
endmodule
`default_nettype wire

// file: tb/lrp_monitor.sv
// assertion checker for the refresh and power-state block
`default_nettype none
module lrp_monitor (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_init_done,
  input wire logic [13:0] o_refresh_row,
  input wire logic        o_refresh_pulse,
  input wire logic        o_buffers_on,
  input wire logic [5:0]  o_state,
  input wire logic        o_data_lost
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  state_onehot_a: assert property ($onehot(o_state))
    else $error("state not one-hot");
  refresh_span_a: assert property ($rose(o_state == 6'h02) |->
    (o_state == 6'h02)[*5] ##1 (o_state != 6'h02)) else $error("refresh span wrong");
  refresh_pulse_a: assert property ($rose(o_state == 6'h02) |-> $past(o_refresh_pulse))
    else $error("no pulse at refresh");
  pulse_single_a: assert property (o_refresh_pulse |=> !o_refresh_pulse)
    else $error("pulse too long");
  row_step_a: assert property ($changed(o_refresh_row) |-> $past(o_refresh_pulse))
    else $error("row moved without refresh");
  buffers_off_a: assert property (|o_state[4:2] |-> !o_buffers_on)
    else $error("buffers on while asleep");
  sref_exit_a: assert property ($fell(o_state == 6'h04) |-> (o_state == 6'h20)[*5])
    else $error("self refresh exit wait wrong");
  pdn_exit_a: assert property ($fell(o_state == 6'h08) |->
    o_state == 6'h20 ##1 o_state == 6'h01) else $error("power-down exit wrong");
  deep_lost_a: assert property (o_state == 6'h10 |-> o_data_lost)
    else $error("deep sleep keeps data");
  lost_clear_a: assert property ($fell(o_data_lost) |-> $past(i_init_done))
    else $error("data lost cleared early");
  cover property (o_state == 6'h04 && o_refresh_pulse);
  cover property (o_state == 6'h08);
  cover property (o_state == 6'h10);
endmodule
bind lrp_power_states lrp_monitor u_mon (.i_clock, .i_srst, .i_init_done, .o_refresh_row,
  .o_refresh_pulse, .o_buffers_on, .o_state, .o_data_lost);
`default_nettype wire

// file: tb/tb_lrp_power_states.sv
// testbench for the refresh and power-state block
`include "lrp_defines.vh"
`default_nettype none
module tb_lrp_power_states;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, srst = 1, cke = 1, init = 0, cke_p, err_seen = 0;
  logic [3:0] cmd = 4'h7, pins;
  logic [13:0] addr = 14'h0000, addr_p, row, r0;
  logic [1:0] par = 2'h0;
  logic pulse, buf_on, lost, cerr;
  logic [5:0] st;
  logic [3:0] banks;
  int error_cnt = 0, compares = 0, n;
  always #12.5 clk = ~clk;
  // cleared in reset so the unknown error output before the first edge cannot stick
  always @(posedge clk) err_seen <= srst ? 1'b0 : (err_seen | cerr);
  lrp_host_model u_host (.i_clock(clk), .i_cmd(cmd), .i_cke(cke), .i_addr(addr),
    .o_cke(cke_p), .o_pins(pins), .o_addr(addr_p));
  lrp_power_states dut (.i_clock(clk), .i_srst(srst), .i_cke(cke_p), .i_cs_n(pins[3]),
    .i_ras_n(pins[2]), .i_cas_n(pins[1]), .i_we_n(pins[0]), .i_addr(addr_p),
    .i_bank(addr_p[12:11]), .i_partial_array_retention(par), .i_temp_hot(1'b1),
    .i_init_done(init), .o_refresh_row(row), .o_refresh_pulse(pulse), .o_buffers_on(buf_on),
    .o_state(st), .o_bank_open(banks), .o_data_lost(lost), .o_cmd_error(cerr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic k);
    @(posedge clk);
    cmd <= c;
    cke <= k;
    @(posedge clk);
    cmd <= `LRP_CMD_NOP;
  endtask
  task automatic wait_st(input logic [5:0] s);
    for (int i = 0; i < 60 && st !== s; i++) @(posedge clk);
    #1;
    chk(st, s);
  endtask
  task automatic t_refresh;
    r0 = row;
    addr <= 14'h2aaa;
    issue(`LRP_CMD_REFRESH, 1'b1);
    wait_st(6'h02);
    chk(row, r0 + 14'h0001);
    wait_st(6'h01);
    issue(`LRP_CMD_REFRESH, 1'b1);
    wait_st(6'h02);
    chk(row, r0 + 14'h0002);
    wait_st(6'h01);
    chk(err_seen, 1'b0);
  endtask
  task automatic t_powerdown;
    addr <= 14'h0800;
    issue(`LRP_CMD_ACTIVE, 1'b1);
    issue(`LRP_CMD_REFRESH, 1'b1);
    repeat (8) @(posedge clk);
    chk(err_seen, 1'b1);
    wait_st(6'h01);
    chk(banks, 4'h2);
    cke <= 1'b0;
    wait_st(6'h08);
    chk({banks, buf_on}, 5'h04);
    cke <= 1'b1;
    wait_st(6'h01);
    addr <= 14'h0400;
    issue(`LRP_CMD_PRECHARGE, 1'b1);
    repeat (5) @(posedge clk);
    chk(banks, 4'h0);
  endtask
  task automatic t_self;
    par <= 2'h1;
    issue(`LRP_CMD_REFRESH, 1'b0);
    wait_st(6'h04);
    issue(`LRP_CMD_ACTIVE, 1'b0);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (pulse === 1'b1) n++;
      if (pulse === 1'b1) chk(row[13], 1'b0);
    end
    chk(n > 1, 1'b1);
    cke <= 1'b1;
    wait_st(6'h20);
    wait_st(6'h01);
    chk({banks, buf_on}, 5'h01);
  endtask
  task automatic t_deep;
    issue(`LRP_CMD_DEEP, 1'b0);
    wait_st(6'h10);
    chk(lost, 1'b1);
    cke <= 1'b1;
    wait_st(6'h01);
    chk(lost, 1'b1);
    init <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(lost, 1'b0);
  endtask
  task automatic summarize;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({st, buf_on, lost}, 8'h07);
    init <= 1'b1;
    repeat (3) @(posedge clk);
    init <= 1'b0;
    t_refresh();
    t_powerdown();
    t_self();
    t_deep();
    summarize();
  end
endmodule
`default_nettype wire
